// [verilog/srp_pkg.sv]
// shared constants and types for the spi register port with packet queue
package srp_pkg;
	// ----------------------------------------
	// queue geometry
	// ----------------------------------------
	localparam int SRP_DEPTH = 64;    // entries of one byte
	localparam int SRP_AW    = 6;     // pointer width
	localparam int SRP_NGEN  = 4;     // spare config registers

	// ----------------------------------------
	// register addresses inside a frame
	// ----------------------------------------
	localparam logic [6:0] SRP_ADDR_FIFO   = 7'h00;
	localparam logic [6:0] SRP_ADDR_THRESH = 7'h01;
	localparam logic [6:0] SRP_ADDR_FLAGS  = 7'h02;
	localparam logic [6:0] SRP_ADDR_GEN0   = 7'h03;

	// ----------------------------------------
	// reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] SRP_THRESH_RST = 8'h0f;
	localparam int SRP_FB_EMPTY = 0;  // flags byte: empty
	localparam int SRP_FB_FULL  = 1;  // flags byte: full
	localparam int SRP_FB_LEVEL = 2;  // flags byte: level
	localparam int SRP_FB_OVR   = 3;  // flags byte: overrun, write 1
	localparam int SRP_FB_SENT  = 4;  // flags byte: frame sent
	localparam int SRP_WNR_BIT  = 7;  // direction bit of address byte

	// ----------------------------------------
	// serial shift unit states
	// ----------------------------------------
	typedef enum logic [2:0] {
		SRP_SU_IDLE = 3'h1,
		SRP_SU_SEND = 3'h2,
		SRP_SU_RECV = 3'h4
	} srp_su_t;
endpackage

// [verilog/srp_spi_port.sv]
// spi slave register port with 64 byte packet queue and serial shift unit
// How it works
// - slave only, clock idles low, phase zero
// - master drives mosi falling, we sample rising
// - miso changes falling, floats while deselected
// - first byte: direction bit, seven address bits
// - data bytes travel most significant bit first
// - non-queue address increments after each data byte
// - queue address holds, every byte hits queue except writes during receive and reads of an empty queue
// - select rising ends frame, next byte addresses
// - write frame returns register's old content, zero at queue address
// - single access is one-byte burst
// - queue is 64 bytes, first in first out
// - transmit shifts queue bytes out msb first
// - receive gathers bits, pushes whole bytes
// - empty flag, held during queue reads until select
// - full flag high only when all occupied
// - write into full queue lost, sets overrun
// - frame sent after final bit leaves
// - level flag updated only on queue access
// - level frozen from full until empty
`timescale 1ns/1ps
`default_nettype none
module srp_spi_port #(
	parameter int DEPTH = srp_pkg::SRP_DEPTH,
	parameter int AW    = srp_pkg::SRP_AW,
	parameter int NGEN  = srp_pkg::SRP_NGEN
) (
	// core clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	// spi link
	input  wire logic        sck_i,
	input  wire logic        sel_b_i,
	input  wire logic        mosi_i,
	output logic             miso_o,
	output logic             miso_oe_b_o,
	// modem side
	input  wire logic        mode_tx_i,
	input  wire logic        mode_rx_i,
	input  wire logic [15:0] bit_period_i,
	output logic             mod_data_o,
	input  wire logic        demod_bit_i,
	input  wire logic        demod_valid_i,
	// status flags
	output logic             queue_empty_flag_o,
	output logic             queue_full_flag_o,
	output logic             queue_level_flag_o,
	output logic             queue_overrun_flag_o,
	output logic             frame_sent_flag_o
);
	import srp_pkg::*;

	// ----------------------------------------
	// state types
	// ----------------------------------------
	typedef struct packed {
		logic [2:0]            tsync;    // byte toggle synchroniser
		logic [2:0]            nsync;    // select synchroniser
		logic                  idx;      // address byte taken
		logic                  wnr;      // frame direction
		logic [6:0]            addr;     // current register address
		logic                  pend;     // prefetch due
		logic                  rd_fifo;  // rd_data is queue head
		logic [7:0]            rd_data;  // next byte for miso
		logic [7:0]            thresh;   // queue_threshold_reg
		logic [NGEN-1:0][7:0]  gen;      // spare config registers
		logic [DEPTH-1:0][7:0] mem;      // queue storage
		logic [AW-1:0]         wp;       // write pointer
		logic [AW-1:0]         rp;       // read pointer
		logic [AW:0]           cnt;      // fill count
		logic                  empty;
		logic                  full;
		logic                  level;
		logic                  lvl_hold; // level frozen after full
		logic                  ovr;
		logic                  sent;
		srp_su_t               st;       // shift unit state
		logic [7:0]            sh;       // shift unit byte
		logic [2:0]            bits;     // bits left or gathered
		logic [15:0]           tmr;      // bit timer
		logic                  mod;      // bit toward modulator
	} srp_core_t;

	typedef struct packed {
		logic [2:0] cnt;   // bit position in byte
		logic [6:0] sh;    // incoming bits
		logic       seen;  // one byte completed
	} srp_frame_t;

	typedef struct packed {
		logic       tgl;   // flips per completed byte
		logic [7:0] data;  // completed byte
	} srp_link_t;

	// select synchroniser starts at the deselected level
	localparam srp_core_t CORE_RST = '{
		empty: 1'b1, thresh: SRP_THRESH_RST, st: SRP_SU_IDLE,
		nsync: 3'h7, default: '0};
	localparam int GW = $clog2(NGEN);

	srp_core_t  q, n;     // core domain
	srp_frame_t f, nf;    // link rise, cleared per frame
	srp_link_t  l, nl;    // link rise, cleared by reset only
	logic [7:0] o, no;    // link fall, miso shifter
	logic       frame_rst_b;

	// core combinational helpers
	logic       byte_ev, fifo_a, rdf, in_gen, tick;
	logic       push, pop, su_pop, su_load, pops, clr, ovr_ev, push_ok;
	logic [7:0] pdat, flags;
	logic [6:0] gi;

	// ----------------------------------------
	// link side, runs on sck
	// ----------------------------------------
	// deselect clears the frame logic
	assign frame_rst_b = rst_b_i & ~sel_b_i;

	// rising edge only, slave shift in
	always_comb begin
		nf = f;
		nl = l;
		nf.sh  = {f.sh[5:0], mosi_i};
		nf.cnt = f.cnt + 3'h1;
		if (f.cnt == 3'h7) begin
			nf.seen = 1'b1;
			nl.tgl  = ~l.tgl;
			nl.data = {f.sh, mosi_i};
		end
	end

	always_ff @(posedge sck_i or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			f <= '0;
		end else begin
			f <= nf;
		end
	end

	always_ff @(posedge sck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			l <= '0;
		end else begin
			l <= nl;
		end
	end

	// miso shifter, loads prefetched byte at byte boundary
	always_comb begin
		no = {o[6:0], 1'b0};
		if (f.cnt == 3'h0 && f.seen) begin
			no = q.rd_data;
		end
	end

	always_ff @(negedge sck_i or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			o <= '0;
		end else begin
			o <= no;
		end
	end

	assign miso_o = o[7];
	// float while deselected or in reset
	assign miso_oe_b_o = sel_b_i | ~rst_b_i;

	// ----------------------------------------
	// core side: frame decode, queue, shift unit
	// ----------------------------------------
	always_comb begin
		n       = q;
		push    = 1'b0;
		pop     = 1'b0;
		su_load = 1'b0;
		su_pop  = 1'b0;
		clr     = 1'b0;
		pdat    = 8'h00;
		n.tsync = {q.tsync[1:0], l.tgl};
		n.nsync = {q.nsync[1:0], sel_b_i};
		byte_ev = q.tsync[2] ^ q.tsync[1];
		fifo_a  = (q.addr == SRP_ADDR_FIFO);
		gi      = q.addr - SRP_ADDR_GEN0;
		in_gen  = (q.addr >= SRP_ADDR_GEN0) && (gi < 7'(NGEN));
		tick    = (q.tmr == 16'h0000);
		flags   = 8'h00;
		flags[SRP_FB_EMPTY] = q.empty;
		flags[SRP_FB_FULL]  = q.full;
		flags[SRP_FB_LEVEL] = q.level;
		flags[SRP_FB_OVR]   = q.ovr;
		flags[SRP_FB_SENT]  = q.sent;

		// deselect: next byte is an address again
		if (q.nsync[1]) begin
			n.idx  = 1'b0;
			n.pend = 1'b0;
		end else if (byte_ev) begin
			n.pend = 1'b1;
			if (!q.idx) begin
				n.idx  = 1'b1;
				n.wnr  = l.data[SRP_WNR_BIT];
				n.addr = l.data[6:0];
			end else begin
				// single access follows the burst path
				if (q.wnr) begin
					if (fifo_a) begin
						// host may not fill during receive
						push = ~mode_rx_i;
						pdat = l.data;
					end else if (q.addr == SRP_ADDR_THRESH) begin
						n.thresh = l.data;
					end else if (q.addr == SRP_ADDR_FLAGS) begin
						clr = l.data[SRP_FB_OVR];
					end else if (in_gen) begin
						n.gen[gi[GW-1:0]] = l.data;
					end
				end else begin
					// head delivered, drop it now
					pop = fifo_a & q.rd_fifo;
				end
				if (!fifo_a) begin
					n.addr = q.addr + 7'h01;
				end
			end
		end

		// prefetch before any write of this byte lands
		if (q.pend) begin
			n.pend    = 1'b0;
			n.rd_fifo = 1'b0;
			if (fifo_a) begin
				// queue address stays on the head
				n.rd_fifo = ~q.wnr && (q.cnt != '0);
				n.rd_data = n.rd_fifo ? q.mem[q.rp] : 8'h00;
			end else if (q.addr == SRP_ADDR_THRESH) begin
				n.rd_data = q.thresh;
			end else if (q.addr == SRP_ADDR_FLAGS) begin
				n.rd_data = flags;
			end else if (in_gen) begin
				n.rd_data = q.gen[gi[GW-1:0]];
			end else begin
				n.rd_data = 8'h00;
			end
		end

		// shift unit
		unique case (q.st)
			SRP_SU_IDLE: begin
				if (mode_tx_i && q.cnt != '0 && !pop) begin
					su_load = 1'b1;
				end else if (mode_rx_i) begin
					n.st   = SRP_SU_RECV;
					n.bits = 3'h0;
				end
			end
			SRP_SU_SEND: begin
				if (!mode_tx_i) begin
					n.st  = SRP_SU_IDLE;
					n.mod = 1'b0;
				end else if (!tick) begin
					n.tmr = q.tmr - 16'h0001;
				end else if (q.bits != 3'h0) begin
					n.tmr  = bit_period_i - 16'h0001;
					n.mod  = q.sh[7];
					n.sh   = {q.sh[6:0], 1'b0};
					n.bits = q.bits - 3'h1;
				end else if (q.cnt != '0 && !pop) begin
					su_load = 1'b1;
				end else begin
					n.st   = SRP_SU_IDLE;
					n.mod  = 1'b0;
					n.sent = 1'b1;
				end
			end
			SRP_SU_RECV: begin
				if (!mode_rx_i) begin
					n.st = SRP_SU_IDLE;
				end else if (demod_valid_i) begin
					n.sh   = {q.sh[6:0], demod_bit_i};
					n.bits = q.bits + 3'h1;
					if (q.bits == 3'h7) begin
						push = 1'b1;
						pdat = {q.sh[6:0], demod_bit_i};
					end
				end
			end
			default: begin
				n.st = SRP_SU_IDLE;
			end
		endcase

		// pull a byte, first bit out at once
		if (su_load) begin
			su_pop = 1'b1;
			n.st   = SRP_SU_SEND;
			n.mod  = q.mem[q.rp][7];
			n.sh   = {q.mem[q.rp][6:0], 1'b0};
			n.bits = 3'h7;
			n.tmr  = bit_period_i - 16'h0001;
			n.sent = 1'b0;
		end
		if (!mode_tx_i) begin
			n.sent = 1'b0;
		end

		pops    = (pop | su_pop) && (q.cnt != '0);
		ovr_ev  = push && (q.cnt == (AW+1)'(DEPTH));
		push_ok = push && !ovr_ev;
		if (clr) begin
			n.wp  = '0;
			n.rp  = '0;
			n.cnt = '0;
		end else begin
			if (push_ok) begin
				n.mem[q.wp] = pdat;
				n.wp        = q.wp + AW'(1);
			end
			if (pops) begin
				n.rp = q.rp + AW'(1);
			end
			n.cnt = q.cnt + (AW+1)'(push_ok) - (AW+1)'(pops);
		end
		n.ovr  = ovr_ev | (q.ovr & ~clr);
		// full only with every entry used
		n.full = (n.cnt == (AW+1)'(DEPTH));
		// held inside a queue read frame
		rdf = ~q.nsync[1] & q.idx & ~q.wnr & fifo_a;
		if (!rdf) begin
			n.empty = (n.cnt == '0);
		end
		if (n.cnt == '0) begin
			n.lvl_hold = 1'b0;
		end else if (n.full) begin
			n.lvl_hold = 1'b1;
		end
		// only a queue access refreshes level
		// a flush cancels the access, so level is left alone
		if ((push | pops) && !clr && !n.lvl_hold) begin
			n.level = {1'b0, n.cnt} > q.thresh;
		end
	end

	// core state register
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= CORE_RST;
		end else begin
			q <= n;
		end
	end

	assign mod_data_o           = q.mod;
	assign queue_empty_flag_o   = q.empty;
	assign queue_full_flag_o    = q.full;
	assign queue_level_flag_o   = q.level;
	assign queue_overrun_flag_o = q.ovr;
	assign frame_sent_flag_o    = q.sent;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence last_bit_s;
		q.st == SRP_SU_SEND && mode_tx_i && tick && q.bits == 3'h0
			&& q.cnt == '0;
	endsequence

	sequence rx_done_s;
		q.st == SRP_SU_RECV && mode_rx_i && demod_valid_i
			&& q.bits == 3'h7 && q.cnt != (AW+1)'(DEPTH) && !pops && !clr;
	endsequence

	miso_float_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) sel_b_i |-> miso_oe_b_o)
		else $error("miso driven while deselected");
	full_flag_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) q.full == (q.cnt == (AW+1)'(DEPTH)))
		else $error("full flag disagrees with fill");
	empty_idle_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) q.nsync[1] |=> q.empty == (q.cnt == '0))
		else $error("empty flag stale outside frame");
	overrun_set_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		ovr_ev |=> q.ovr && (q.cnt != '0 || $past(clr)))
		else $error("overrun not raised");
	flush_ptr_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) clr |=> q.cnt == '0 && q.wp == q.rp)
		else $error("flush left data");
	addr_step_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		(byte_ev && !q.nsync[1] && q.idx && !fifo_a)
		|=> q.addr == $past(q.addr) + 7'h01)
		else $error("address not incremented");
	addr_hold_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		(byte_ev && !q.nsync[1] && q.idx && fifo_a) |=> $stable(q.addr))
		else $error("queue address moved");
	frame_end_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) q.nsync[1] |=> !q.idx)
		else $error("frame state kept after deselect");
	level_still_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) !(push || pops) |=> $stable(q.level))
		else $error("level moved without access");
	level_frozen_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) q.full |=> $stable(q.level))
		else $error("level moved after full");
	sent_flag_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i) last_bit_s |=> q.sent && !mod_data_o)
		else $error("frame sent not raised");
	bit_hold_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		(q.st == SRP_SU_SEND && mode_tx_i && !tick) |=> $stable(q.mod))
		else $error("tx bit changed mid period");
	rx_push_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		rx_done_s |=> q.cnt == $past(q.cnt) + (AW+1)'(1))
		else $error("received byte not queued");
endmodule
`default_nettype wire

// [test/srp_spi_master.sv]
// spi master model that drives frames into the register port
`timescale 1ns/1ps
`default_nettype none
module srp_spi_master (
	// spi link toward the port
	output logic      sck_o,
	output logic      sel_b_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	// ----------------------------------------
	// idle levels
	// ----------------------------------------
	// clock idles low
	initial begin
		sck_o   = 1'b0;
		sel_b_o = 1'b1;
		mosi_o  = 1'b0;
	end

	// ----------------------------------------
	// frame tasks, 160 ns link period
	// ----------------------------------------
	// select low, odd offset keeps phase unrelated to core
	task automatic open_frame();
		#37 sel_b_o = 1'b0;
		#80;
	endtask

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			#80 sck_o = 1'b1;
			rx[i] = miso_i;
			#80 sck_o = 1'b0;
		end
	endtask

	task automatic close_frame();
		#80 sel_b_o = 1'b1;
		mosi_o = ~mosi_o;
		#120;
	endtask
endmodule
`default_nettype wire

// [test/srp_spi_port_test.sv]
// self-checking bench for the spi register port with packet queue
`timescale 1ns/1ps
`default_nettype none
module srp_spi_port_test;
	import srp_pkg::*;
	// ----------------------------------------
	// stimulus and observation signals
	// ----------------------------------------
	logic        core_clk    = 1'b0;  // 125 MHz core clock
	logic        rst_b       = 1'b0;  // async reset, active low
	logic        sck, sel_b, mosi;    // from master model
	logic        miso, miso_oe_b;     // slave data and enable
	wire  logic  miso_w;              // resolved miso line
	logic        mode_tx     = 1'b0;  // transmit mode
	logic        mode_rx     = 1'b0;  // receive mode
	logic [15:0] bit_period  = 16'h0006; // cycles per sent bit
	logic        mod_data;            // bit toward modulator
	logic        demod_bit   = 1'b0;  // received bit
	logic        demod_valid = 1'b0;  // received bit strobe
	wire  logic [7:0] flags;          // flags in flags-byte order
	logic [7:0]  tx_q[$];             // bytes sent in a frame
	logic [7:0]  rx_q[$];             // bytes seen in a frame
	logic [7:0]  got;                 // serial byte work value
	int          errors      = 0;
	int          n_compared  = 0;
	int          cycles      = 0;

	assign miso_w = miso_oe_b ? 1'bz : miso;
	assign flags[7:5] = 3'h0;

	// ----------------------------------------
	// design and master model
	// ----------------------------------------
	srp_spi_port i_dut (
		.core_clk_i(core_clk), .rst_b_i(rst_b),
		.sck_i(sck), .sel_b_i(sel_b), .mosi_i(mosi),
		.miso_o(miso), .miso_oe_b_o(miso_oe_b),
		.mode_tx_i(mode_tx), .mode_rx_i(mode_rx),
		.bit_period_i(bit_period), .mod_data_o(mod_data),
		.demod_bit_i(demod_bit), .demod_valid_i(demod_valid),
		.queue_empty_flag_o(flags[SRP_FB_EMPTY]),
		.queue_full_flag_o(flags[SRP_FB_FULL]),
		.queue_level_flag_o(flags[SRP_FB_LEVEL]),
		.queue_overrun_flag_o(flags[SRP_FB_OVR]),
		.frame_sent_flag_o(flags[SRP_FB_SENT])
	);
	srp_spi_master i_master (
		.sck_o(sck), .sel_b_o(sel_b), .mosi_o(mosi), .miso_i(miso_w)
	);

	// core clock, 8 ns period
	initial forever #4 core_clk = ~core_clk;

	// hang guard, about three times the expected run
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 80000) begin
			errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// checking and access tasks
	// ----------------------------------------
	// compare, count, report a mismatch
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	// counts and verdict
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// address byte then n data bytes, select left low
	task automatic frame(input logic wnr, input logic [6:0] a, input int n);
		logic [7:0] r;
		rx_q = {};
		i_master.open_frame();
		i_master.xfer({wnr, a}, r);
		check(r, 8'h00);
		for (int i = 0; i < n; i++) begin
			i_master.xfer(wnr ? tx_q[i] : 8'h00, r);
			rx_q.push_back(r);
		end
	endtask

	// single write, one data byte
	task automatic wr1(input logic [6:0] a, input logic [7:0] d);
		tx_q = {d};
		frame(1'b1, a, 1);
		i_master.close_frame();
	endtask

	// single read, one data byte
	task automatic rd1(input logic [6:0] a);
		frame(1'b0, a, 1);
		i_master.close_frame();
	endtask

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (5) @(negedge core_clk);
		check(flags, 8'h01);
		check({7'h00, miso_oe_b}, 8'h01);
		frame(1'b0, SRP_ADDR_THRESH, 1);
		check({7'h00, miso_oe_b}, 8'h00);
		i_master.close_frame();
		check(rx_q[0], SRP_THRESH_RST);
		$display("test single read done");

		// burst runs past the last spare register
		tx_q = {8'h31, 8'h42, 8'h53, 8'h64, 8'h75};
		frame(1'b1, SRP_ADDR_GEN0, 5);
		i_master.close_frame();
		foreach (rx_q[i])
			check(rx_q[i], 8'h00);
		frame(1'b0, SRP_ADDR_GEN0, 5);
		i_master.close_frame();
		for (int i = 0; i < 4; i++)
			check(rx_q[i], tx_q[i]);
		check(rx_q[4], 8'h00);
		wr1(SRP_ADDR_GEN0 + 7'h02, 8'h99);
		check(rx_q[0], 8'h53);
		$display("test burst done");

		// fill to full plus one, then drain in one frame
		tx_q = {};
		for (int i = 0; i < 65; i++)
			tx_q.push_back(8'(i * 3 + 1));
		frame(1'b1, SRP_ADDR_FIFO, 65);
		i_master.close_frame();
		check(flags, 8'h0e);
		frame(1'b0, SRP_ADDR_FIFO, 64);
		check(flags & 8'h01, 8'h00);
		i_master.close_frame();
		for (int i = 0; i < 64; i++)
			check(rx_q[i], tx_q[i]);
		check(flags & 8'h0b, 8'h09);
		$display("test queue fill done");

		// level follows accesses, not threshold writes
		wr1(SRP_ADDR_THRESH, 8'h01);
		wr1(SRP_ADDR_FIFO, 8'h11);
		check(flags & 8'h04, 8'h00);
		wr1(SRP_ADDR_FIFO, 8'h22);
		check(flags & 8'h04, 8'h04);
		wr1(SRP_ADDR_THRESH, 8'h05);
		check(flags & 8'h04, 8'h04);
		rd1(SRP_ADDR_FIFO);
		check(rx_q[0], 8'h11);
		check(flags & 8'h04, 8'h00);
		$display("test level done");

		// overrun clear flushes the queue
		wr1(SRP_ADDR_FLAGS, 8'h08);
		check(rx_q[0], 8'h08);
		check(flags, 8'h01);
		$display("test flush done");

		// transmit one byte at six cycles per bit
		wr1(SRP_ADDR_FIFO, 8'ha5);
		@(negedge core_clk);
		mode_tx = 1'b1;
		for (int i = 0; i < 50 && mod_data !== 1'b1; i++)
			@(negedge core_clk);
		repeat (2) @(negedge core_clk);
		for (int i = 7; i >= 0; i--) begin
			got[i] = mod_data;
			repeat (6) @(negedge core_clk);
		end
		check(got, 8'ha5);
		for (int i = 0; i < 20 && flags[SRP_FB_SENT] !== 1'b1; i++)
			@(negedge core_clk);
		check(flags & 8'h11, 8'h11);
		mode_tx = 1'b0;
		$display("test transmit done");

		// receive one byte bit by bit
		mode_rx = 1'b1;
		// mode switch settles before queue traffic
		@(negedge core_clk);
		got = 8'h5a;
		for (int i = 7; i >= 0; i--) begin
			demod_bit = got[i];
			demod_valid = 1'b1;
			@(negedge core_clk);
			demod_valid = 1'b0;
			repeat (2) @(negedge core_clk);
		end
		repeat (4) @(negedge core_clk);
		rd1(SRP_ADDR_FIFO);
		check(rx_q[0], 8'h5a);
		check(flags & 8'h01, 8'h01);
		@(negedge core_clk);
		mode_rx = 1'b0;
		$display("test receive done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
